// ---- hw/dual_log_pot_wiper_update.sv ----
// Serial slave, command decode, wiper update and store sequencing
`timescale 1ns/1ps
module dual_log_pot_wiper_update
	import pot_pkg::*;
#(
	parameter int WIN_CYCLES = WINDOW_CYCLES
) (
	input  wire logic              core_clk,
	input  wire logic              srst,
	input  wire logic              link_clk,
	input  wire logic              scl,
	input  wire logic              sda_i,
	output logic                   sda_o,
	output logic                   sda_oe,
	input  wire logic              chip_enable_n,
	input  wire logic              addr_select_bit0,
	input  wire logic              addr_select_bit1,
	input  wire logic              addr_select_bit2,
	input  wire logic              pot0_terminals_equal,
	input  wire logic              pot1_terminals_equal,
	output logic      [CODE_W-1:0] pot0_wiper_terminal,
	output logic      [CODE_W-1:0] pot1_wiper_terminal,
	output logic      [DB_W-1:0]   pot0_atten_db,
	output logic      [DB_W-1:0]   pot1_atten_db,
	output logic                   volatile_storage_select,
	output logic                   zc_enable,
	output logic                   taper_option_select,
	output logic      [N_CH-1:0]   window_busy,
	output logic                   nv_write_start
);

	// ----------------------------------------------------------------
	// Link domain state
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		L_IDLE  = 3'h0,     // Waiting for START
		L_ADDR  = 3'h1,     // Shifting address byte
		L_ACK_A = 3'h2,     // Acknowledging address
		L_CMD   = 3'h3,     // Shifting command byte
		L_ACK_C = 3'h4,     // Acknowledging command
		L_SKIP  = 3'h5      // Not addressed, wait for next START
	} link_state_t;

	typedef struct packed {
		logic        rst_s1;     // Reset synchroniser, first stage
		logic        rst_s2;     // Link domain reset
		pins_t       pins_s1;    // Pin synchroniser, first stage
		pins_t       pins_s2;    // Pins safe to read
		logic        scl_prev;   // For edge detection
		logic        sda_prev;
		link_state_t st;
		logic [3:0]  bit_cnt;    // Bits shifted in this byte
		logic [7:0]  shreg;      // Incoming byte
		logic        sda_oe;     // Pulling data low for acknowledge
		cmd_t        cmd;        // Last command, held until the next
		logic        cmd_tgl;    // Flips once per acknowledged command
		logic        stop_tgl;   // Flips once per STOP that ends an addressed write
	} link_t;

	// ----------------------------------------------------------------
	// Core domain state
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [2:0]                   cmd_sync;   // Two stages plus history
		logic [2:0]                   stop_sync;
		logic [N_CH-1:0]              eq_s1;      // Crossing inputs, first stage
		logic [N_CH-1:0]              eq_s2;
		cfg_t                         cfg;
		logic [N_CH-1:0][CODE_W-1:0]  wiper;      // Active tap codes
		logic [N_CH-1:0][CODE_W-1:0]  pend;       // Codes waiting for a window
		logic                         nv_pend;    // Store owed
		logic                         stop_seen;  // STOP since last command
		logic                         nv_start;
	} core_t;

	link_t lq;
	link_t ln;
	core_t cq;
	core_t cn;

	pins_t           pins_raw;     // Pins as they arrive
	logic            scl_rise;
	logic            scl_fall;
	logic            start_c;      // START condition seen
	logic            stop_c;       // STOP condition seen
	logic [7:0]      own_addr;     // Expected address byte
	logic            cmd_evt;      // Command arrived in core domain
	logic            stop_evt;     // STOP arrived in core domain
	logic            cmd_is_wiper;
	logic            cmd_ch;       // Addressed channel
	logic [N_CH-1:0] win_start;
	logic [N_CH-1:0] win_apply;
	logic [DB_W-1:0] atten [N_CH];

	// ----------------------------------------------------------------
	// Link side: pin sampling and serial slave
	// ----------------------------------------------------------------
	assign pins_raw = '{scl: scl, sda: sda_i, ce_n: chip_enable_n,
		addr: {addr_select_bit2, addr_select_bit1, addr_select_bit0}};

	// Sampling clock must be far faster than the serial clock
	assign scl_rise = lq.pins_s2.scl & ~lq.scl_prev;
	assign scl_fall = ~lq.pins_s2.scl & lq.scl_prev;
	assign start_c  = lq.pins_s2.scl & lq.scl_prev & lq.sda_prev & ~lq.pins_s2.sda;
	assign stop_c   = lq.pins_s2.scl & lq.scl_prev & ~lq.sda_prev & lq.pins_s2.sda;
	assign own_addr = {ADDR_HI, lq.pins_s2.addr, RW_WRITE};

	// Slave sequencer; reads are not served and get no acknowledge
	always_comb begin
		ln = lq;
		ln.rst_s1 = srst;
		ln.rst_s2 = lq.rst_s1;
		ln.pins_s1 = pins_raw;
		ln.pins_s2 = lq.pins_s1;
		ln.scl_prev = lq.pins_s2.scl;
		ln.sda_prev = lq.pins_s2.sda;
		if (lq.rst_s2) begin
			ln.st = L_IDLE;
			ln.bit_cnt = '0;
			ln.shreg = '0;
			ln.sda_oe = 1'b0;
			ln.cmd = '0;
			ln.cmd_tgl = 1'b0;
			ln.stop_tgl = 1'b0;
		end else if (lq.pins_s2.ce_n) begin
			// Disabled: release the data line and forget the transfer
			ln.st = L_IDLE;
			ln.sda_oe = 1'b0;
		end else if (start_c) begin
			ln.st = L_ADDR;
			ln.bit_cnt = '0;
			ln.sda_oe = 1'b0;
		end else if (stop_c) begin
			// Only a STOP that ends an addressed write is passed on
			if (lq.st == L_CMD || lq.st == L_ACK_C) begin
				ln.stop_tgl = ~lq.stop_tgl;
			end
			ln.st = L_IDLE;
			ln.sda_oe = 1'b0;
		end else begin
			case (lq.st)
				L_ADDR, L_CMD: begin
					if (scl_rise) begin
						ln.shreg = {lq.shreg[6:0], lq.pins_s2.sda};
						ln.bit_cnt = 4'(lq.bit_cnt + 1'b1);
					end else if (scl_fall && lq.bit_cnt == BYTE_BITS) begin
						ln.bit_cnt = '0;
						if (lq.st == L_CMD) begin
							ln.st = L_ACK_C;
							ln.sda_oe = 1'b1;
							ln.cmd = lq.shreg;
							ln.cmd_tgl = ~lq.cmd_tgl;
						end else if (lq.shreg == own_addr) begin
							ln.st = L_ACK_A;
							ln.sda_oe = 1'b1;
						end else begin
							ln.st = L_SKIP;
						end
					end
				end
				L_ACK_A, L_ACK_C: begin
					// Acknowledge held for one serial clock period
					if (scl_fall) begin
						ln.st = L_CMD;
						ln.sda_oe = 1'b0;
					end
				end
				L_IDLE, L_SKIP: begin
					ln.sda_oe = 1'b0;
				end
				default: begin
					ln.st = L_IDLE;
					ln.sda_oe = 1'b0;
				end
			endcase
		end
	end

	always_ff @(posedge link_clk) begin
		lq <= ln;
	end

	assign sda_o  = 1'b0;
	assign sda_oe = lq.sda_oe;

	// ----------------------------------------------------------------
	// Core side: command decode and wiper update
	// ----------------------------------------------------------------
	// Command data is held by the link until the next byte, long after the
	// toggle has crossed, so it is stable when the event is seen here
	assign cmd_evt      = cq.cmd_sync[1] ^ cq.cmd_sync[2];
	assign stop_evt     = cq.stop_sync[1] ^ cq.stop_sync[2];
	assign cmd_is_wiper = (lq.cmd.sel == SEL_POT0) || (lq.cmd.sel == SEL_POT1);
	assign cmd_ch       = lq.cmd.sel[0];

	// Per channel window and attenuation map
	for (genvar g = 0; g < N_CH; g++) begin : g_ch
		assign win_start[g] = cmd_evt & cmd_is_wiper & (cmd_ch == 1'(g))
			& cq.cfg.zc_enable;
		zc_window #(
			.WIN_CYCLES (WIN_CYCLES)
		) u_win (
			.core_clk        (core_clk),
			.srst            (srst),
			.start           (win_start[g]),
			.terminals_equal (cq.eq_s2[g]),
			.apply           (win_apply[g]),
			.busy            (window_busy[g])
		);
		// One option bit drives both maps
		tap_atten_map u_map (
			.taper_option_select (cq.cfg.taper_option_select),
			.code                (cq.wiper[g]),
			.atten_db            (atten[g])
		);
	end

	// Decode, apply and store sequencing; a new set wins over any clear except reset
	always_comb begin
		cn = cq;
		cn.cmd_sync = {cq.cmd_sync[1:0], lq.cmd_tgl};
		cn.stop_sync = {cq.stop_sync[1:0], lq.stop_tgl};
		cn.eq_s1 = {pot1_terminals_equal, pot0_terminals_equal};
		cn.eq_s2 = cq.eq_s1;
		cn.nv_start = 1'b0;
		// Windows that close hand over their pending codes
		for (int i = 0; i < N_CH; i++) begin
			if (win_apply[i]) begin
				cn.wiper[i] = cq.pend[i];
			end
		end
		// Store begins once STOP is seen and no crossing wait remains
		if (cq.nv_pend && cq.stop_seen && !(cq.cfg.zc_enable && |window_busy)) begin
			cn.nv_start = 1'b1;
			cn.nv_pend = 1'b0;
			cn.stop_seen = 1'b0;
		end
		if (cmd_evt) begin
			cn.stop_seen = 1'b0;
			case (lq.cmd.sel)
				SEL_POT0, SEL_POT1: begin
					cn.pend[cmd_ch] = lq.cmd.arg;
					if (!cq.cfg.zc_enable) begin
						cn.wiper[cmd_ch] = lq.cmd.arg;
					end
					// Volatile wipers are never stored
					if (!cq.cfg.volatile_storage_select) begin
						cn.nv_pend = 1'b1;
					end
				end
				SEL_CFG: begin
					cn.cfg = lq.cmd.arg[2:0];
					cn.nv_pend = 1'b1;
				end
				default: begin
					// Reserved select takes no action
				end
			endcase
		end
		if (stop_evt) begin
			cn.stop_seen = 1'b1;
		end
		// Reset leaves the toggle synchronisers running so no stale edge
		// is seen as a command afterwards
		if (srst) begin
			cn.cfg = CFG_RESET;
			cn.wiper = {N_CH{OPT1_MUTE}};
			cn.pend = {N_CH{OPT1_MUTE}};
			cn.nv_pend = 1'b0;
			cn.stop_seen = 1'b0;
			cn.nv_start = 1'b0;
		end
	end

	always_ff @(posedge core_clk) begin
		cq <= cn;
	end

	assign pot0_wiper_terminal     = cq.wiper[0];
	assign pot1_wiper_terminal     = cq.wiper[1];
	assign pot0_atten_db           = atten[0];
	assign pot1_atten_db           = atten[1];
	assign volatile_storage_select = cq.cfg.volatile_storage_select;
	assign zc_enable               = cq.cfg.zc_enable;
	assign taper_option_select     = cq.cfg.taper_option_select;
	assign nv_write_start          = cq.nv_start;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	immediate_move_a: assert property (@(posedge core_clk) disable iff (srst)
		(cmd_evt && lq.cmd.sel == SEL_POT1 && !cq.cfg.zc_enable)
		|=> pot1_wiper_terminal == $past(lq.cmd.arg))
		else $error("wiper not moved at once");
	window_open_a: assert property (@(posedge core_clk) disable iff (srst)
		(cmd_evt && lq.cmd.sel == SEL_POT0 && cq.cfg.zc_enable)
		|=> window_busy[0] ##0 $stable(pot0_wiper_terminal))
		else $error("window not opened");
	store_wait_a: assert property (@(posedge core_clk) disable iff (srst)
		nv_write_start |-> $past(cq.stop_seen) && !$past(zc_enable && |window_busy))
		else $error("store started too early");
	config_write_a: assert property (@(posedge core_clk) disable iff (srst)
		(cmd_evt && lq.cmd.sel == SEL_CFG)
		|=> {volatile_storage_select, zc_enable, taper_option_select}
			== $past(lq.cmd.arg[2:0]))
		else $error("config not written");
	reserved_noop_a: assert property (@(posedge core_clk) disable iff (srst)
		(cmd_evt && lq.cmd.sel == SEL_RSVD && window_busy == '0)
		|=> $stable(cq.cfg) && $stable(cq.wiper) && $stable(cq.pend))
		else $error("reserved command acted");
	reset_default_a: assert property (@(posedge core_clk)
		$past(srst) |-> taper_option_select && zc_enable && pot0_wiper_terminal == OPT1_MUTE)
		else $error("wrong state after reset");
	opt1_map_a: assert property (@(posedge core_clk) disable iff (srst)
		taper_option_select |-> pot0_atten_db ==
			((pot0_wiper_terminal == OPT1_MUTE) ? MUTE_DB : {1'b0, pot0_wiper_terminal}))
		else $error("option one map wrong");
	opt2_mute_a: assert property (@(posedge core_clk) disable iff (srst)
		(!taper_option_select && pot1_wiper_terminal == OPT2_MUTE) |-> pot1_atten_db == MUTE_DB)
		else $error("option two mute wrong");
	disabled_quiet_a: assert property (@(posedge link_clk) disable iff (lq.rst_s2)
		lq.pins_s2.ce_n |=> !sda_oe)
		else $error("acknowledge while disabled");
	addr_match_a: assert property (@(posedge link_clk) disable iff (lq.rst_s2)
		(lq.st == L_ACK_A && $past(lq.st) == L_ADDR) |-> $past(lq.shreg) == $past(own_addr))
		else $error("wrong address acknowledged");

	immediate_c: cover property (@(posedge core_clk) disable iff (srst)
		cmd_evt && cmd_is_wiper && !cq.cfg.zc_enable);
	crossing_c: cover property (@(posedge core_clk) disable iff (srst)
		|(win_apply & cq.eq_s2));
	store_c: cover property (@(posedge core_clk) disable iff (srst) nv_write_start);

endmodule : dual_log_pot_wiper_update

// ---- hw/pot_pkg.sv ----
// Shared constants and carrier types for the dual log potentiometer control
package pot_pkg;

	// ----------------------------------------------------------------
	// Sizes
	// ----------------------------------------------------------------
	localparam int N_CH   = 2;                // Potentiometer channels
	localparam int CODE_W = 6;                // Tap code width
	localparam int DB_W   = 7;                // Attenuation width in dB

	// ----------------------------------------------------------------
	// Command byte decode
	// ----------------------------------------------------------------
	localparam logic [1:0] SEL_POT0 = 2'h0;    // Channel 0 wiper
	localparam logic [1:0] SEL_POT1 = 2'h1;    // Channel 1 wiper
	localparam logic [1:0] SEL_CFG  = 2'h2;    // Configuration
	localparam logic [1:0] SEL_RSVD = 2'h3;    // Reserved, no action
	localparam logic [3:0] BYTE_BITS = 4'h8;   // Bits per bus byte
	localparam logic       RW_WRITE  = 1'b0;   // Only writes are served
	localparam logic [3:0] ADDR_HI   = 4'h5;   // Fixed upper address bits

	// ----------------------------------------------------------------
	// Configuration and tap tables
	// ----------------------------------------------------------------
	localparam logic [2:0] CFG_RESET = 3'h7;   // Volatile, crossing on, option one
	localparam logic [5:0] OPT1_MUTE = 6'h3f;  // Option one mute code
	localparam logic [5:0] OPT2_MUTE = 6'h21;  // Option two mute code
	localparam logic [5:0] OPT2_SEG1 = 6'h0c;  // Last 1dB code of option two
	localparam logic [5:0] OPT2_SEG2 = 6'h18;  // Last 2dB code of option two
	localparam logic [6:0] SEG2_OFS  = 7'h0c;  // 2*code minus this in segment two
	localparam logic [6:0] SEG3_OFS  = 7'h24;  // 3*code minus this in segment three
	localparam logic [6:0] MUTE_DB   = 7'h50;  // Attenuation reported for mute

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int CORE_CLK_HZ   = 10_000_000;
	localparam int WINDOW_MS     = 50;        // Update window length
	localparam int WINDOW_CYCLES = WINDOW_MS * (CORE_CLK_HZ / 1000);
	localparam int SCL_MAX_KHZ   = 400;       // Fastest serial clock served

	// ----------------------------------------------------------------
	// Carriers
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [1:0]        sel;               // Target select
		logic [CODE_W-1:0] arg;               // Tap code or config bits
	} cmd_t;

	typedef struct packed {
		logic volatile_storage_select;        // Bit 2
		logic zc_enable;                      // Bit 1
		logic taper_option_select;            // Bit 0, 1 selects option one
	} cfg_t;

	typedef struct packed {
		logic       scl;
		logic       sda;
		logic       ce_n;
		logic [2:0] addr;
	} pins_t;

endpackage : pot_pkg

// ---- hw/tap_atten_map.sv ----
// Tap code to attenuation translation for one channel
`timescale 1ns/1ps
module tap_atten_map
	import pot_pkg::*;
(
	input  wire logic              taper_option_select,
	input  wire logic [CODE_W-1:0] code,
	output logic      [DB_W-1:0]   atten_db
);

	logic [DB_W-1:0] c7;    // Code widened to the dB width

	assign c7 = {1'b0, code};

	// Option one is linear up to mute, option two has three slopes
	always_comb begin
		if (taper_option_select) begin
			atten_db = (code == OPT1_MUTE) ? MUTE_DB : c7;
		end else if (code <= OPT2_SEG1) begin
			atten_db = c7;
		end else if (code <= OPT2_SEG2) begin
			atten_db = DB_W'((c7 << 1) - SEG2_OFS);
		end else if (code < OPT2_MUTE) begin
			atten_db = DB_W'((c7 << 1) + c7 - SEG3_OFS);
		end else begin
			// Codes above the mute code are treated as mute
			atten_db = MUTE_DB;
		end
	end

endmodule : tap_atten_map

// ---- hw/zc_window.sv ----
// Per channel update window with zero crossing or expiry apply
`timescale 1ns/1ps
module zc_window
	import pot_pkg::*;
#(
	parameter int WIN_CYCLES = WINDOW_CYCLES
) (
	input  wire logic core_clk,
	input  wire logic srst,
	input  wire logic start,
	input  wire logic terminals_equal,
	output logic      apply,
	output logic      busy
);

	localparam int              CNT_W = $clog2(WIN_CYCLES);
	localparam logic [CNT_W-1:0] LAST = CNT_W'(WIN_CYCLES - 1);

	typedef struct packed {
		logic             busy;           // Window open
		logic [CNT_W-1:0] count;          // Cycles since opening
	} win_t;

	win_t q;
	win_t n;

	// A restart inside the window reloads the count; the old code is dropped
	always_comb begin
		n = q;
		apply = 1'b0;
		// Expiry applies the code whatever the signal level is
		if (q.busy && !start && (terminals_equal || q.count == LAST)) begin
			apply = 1'b1;
			n.busy = 1'b0;
		end else if (q.busy) begin
			n.count = CNT_W'(q.count + 1'b1);
		end
		if (start) begin
			n.busy = 1'b1;
			n.count = '0;
		end
		if (srst) begin
			n = '0;
		end
	end

	always_ff @(posedge core_clk) begin
		q <= n;
	end

	assign busy = q.busy;

	expiry_apply_a: assert property (@(posedge core_clk) disable iff (srst)
		(q.busy && q.count == LAST && !start) |-> apply)
		else $error("window expired without applying");
	crossing_apply_a: assert property (@(posedge core_clk) disable iff (srst)
		(q.busy && terminals_equal && !start) |=> !busy)
		else $error("crossing did not close window");

endmodule : zc_window

// ---- bench/serial_master_model.sv ----
// Two-wire bus master model that writes command bytes to the device
`timescale 1ns/1ps
module serial_master_model (
	output logic      scl,
	output logic      sda_low,
	input  wire logic sda,
	output logic      chip_enable_n
);
	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int HALF = 1300;   // Half period in ns, about 385kHz: under the fast-mode cap

	// Clock idles high and stands still between frames; data released
	initial begin
		scl           = 1'b1;
		sda_low       = 1'b0;
		chip_enable_n = 1'b1;
	end

	// Start from idle or as a repeated start, enable asserted first
	task automatic start_cond();
		chip_enable_n = 1'b0;
		sda_low = 1'b0;
		#(HALF/2) scl = 1'b1;
		#HALF sda_low = 1'b1;
		#HALF scl = 1'b0;
	endtask : start_cond

	// Data moves only mid-low so it never looks like start or stop
	task automatic send_byte(input logic [7:0] b, output logic ack);
		for (int i = 7; i >= 0; i--) begin
			#(HALF/2) sda_low = ~b[i];
			#(HALF/2) scl = 1'b1;
			#HALF scl = 1'b0;
		end
		#(HALF/2) sda_low = 1'b0;
		#(HALF/2) scl = 1'b1;
		#(HALF/2) ack = ~sda;
		#(HALF/2) scl = 1'b0;
	endtask : send_byte

	// Stop, then enable is dropped only after the bus is free
	task automatic stop_cond();
		#(HALF/2) sda_low = 1'b1;
		#(HALF/2) scl = 1'b1;
		#HALF sda_low = 1'b0;
		#HALF chip_enable_n = 1'b1;
	endtask : stop_cond
endmodule : serial_master_model

// ---- bench/dual_log_pot_wiper_update_test.sv ----
// Self-checking bench for the dual log potentiometer wiper update block
`timescale 1ns/1ps
module dual_log_pot_wiper_update_test;
	import pot_pkg::*;
	localparam int WIN = 20;   // Short window keeps the run brief
	logic             core_clk, link_clk, srst, ce_block, eq0, eq1, stopped, ack;
	logic [2:0]       apins;
	logic [7:0]       addr_byte;
	int               failures, cmp_count, nv_cnt, bad_nv, n, n0;
	wire              m_scl, m_low, m_ce_n, sda_o, sda_oe, vol, zce, opt, nvs;
	wire              sda = ~(m_low | (sda_oe & ~sda_o));   // Pulled-up open-drain line
	wire [CODE_W-1:0] w0, w1;
	wire [DB_W-1:0]   d0, d1;
	wire [N_CH-1:0]   busy;
	typedef struct packed {
		logic [7:0] cfg;   // Config command byte
		logic [7:0] cmd;   // Wiper command byte
		logic [7:0] db;    // Expected attenuation
	} row_t;
	row_t rows [10] = '{
		'{8'h85, 8'h00, 8'h00}, '{8'h85, 8'h3e, 8'h3e}, '{8'h85, 8'h7f, 8'h50},
		'{8'h84, 8'h0c, 8'h0c}, '{8'h84, 8'h4d, 8'h0e}, '{8'h84, 8'h18, 8'h24},
		'{8'h84, 8'h59, 8'h27}, '{8'h84, 8'h20, 8'h3c}, '{8'h84, 8'h61, 8'h50},
		'{8'h81, 8'h41, 8'h01}};

	dual_log_pot_wiper_update #(.WIN_CYCLES(WIN)) u_dut (
		.core_clk(core_clk), .srst(srst), .link_clk(link_clk), .scl(m_scl),
		.sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe), .chip_enable_n(m_ce_n | ce_block),
		.addr_select_bit0(apins[0]), .addr_select_bit1(apins[1]), .addr_select_bit2(apins[2]),
		.pot0_terminals_equal(eq0), .pot1_terminals_equal(eq1),
		.pot0_wiper_terminal(w0), .pot1_wiper_terminal(w1), .pot0_atten_db(d0),
		.pot1_atten_db(d1), .volatile_storage_select(vol), .zc_enable(zce),
		.taper_option_select(opt), .window_busy(busy), .nv_write_start(nvs));
	serial_master_model u_master (.scl(m_scl), .sda_low(m_low), .sda(sda),
		.chip_enable_n(m_ce_n));

	// ----------------------------------------------------------------
	// Clocks, monitors and helpers
	// ----------------------------------------------------------------
	initial begin
		core_clk = 1'b0;
		forever #50 core_clk = ~core_clk;
	end
	// Link clock offset so its edges never line up with the core's
	initial begin
		link_clk = 1'b0;
		#1.7;
		forever #3 link_clk = ~link_clk;
	end
	// Stop and start seen on the wire, to judge when a store may begin
	always @(posedge sda) if (m_scl) stopped = 1'b1;
	always @(negedge sda) if (m_scl) stopped = 1'b0;
	always @(posedge core_clk) begin
		nv_cnt <= nv_cnt + int'(nvs);
		if (nvs && (!stopped || (zce && |busy))) bad_nv <= bad_nv + 1;
	end
	task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			failures++;
			$display("unexpected %s: expected %h seen %h", nm, exp, seen);
		end
	endtask : check
	// One frame: start, address, one or two command bytes, stop
	task automatic xfer(input logic [7:0] c0, input logic [7:0] c1, input logic two);
		logic a;
		u_master.start_cond();
		u_master.send_byte(addr_byte, ack);
		u_master.send_byte(c0, a);
		ack &= a;
		if (two) begin
			u_master.send_byte(c1, a);
			ack &= a;
		end
		u_master.stop_cond();
		@(negedge core_clk);
	endtask : xfer
	task automatic do_reset();
		srst = 1'b1;
		repeat (4) @(negedge core_clk);
		srst = 1'b0;
		repeat (4) @(negedge core_clk);
		check("config", {5'h0, vol, zce, opt}, {5'h0, CFG_RESET});
		check("wiper0", {2'h0, w0}, {2'h0, OPT1_MUTE});
		check("wiper1", {2'h0, w1}, {2'h0, OPT1_MUTE});
		check("atten1", {1'h0, d1}, 8'h50);
		check("busy", {6'h0, busy}, 8'h00);
	endtask : do_reset
	task automatic results();
		$display("comparisons %0d mismatches %0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : results
	// Watchdog sized at about four times the expected run
	initial begin
		repeat (60000) @(posedge core_clk);
		failures++;
		results();
	end

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		{srst, ce_block, eq0, eq1, stopped} = 5'h11;
		apins = 3'h7;
		addr_byte = {ADDR_HI, 3'h7, RW_WRITE};
		do_reset();
		// Tap tables under both options, crossing detection off
		foreach (rows[i]) begin
			n = nv_cnt;
			xfer(rows[i].cfg, rows[i].cmd, 1'b1);
			check("ack", {7'h0, ack}, 8'h01);
			check("option", {7'h0, opt}, {7'h0, rows[i].cfg[0]});
			check("wiper", rows[i].cmd[6] ? {2'h0, w1} : {2'h0, w0}, {2'h0, rows[i].cmd[5:0]});
			check("atten", rows[i].cmd[6] ? {1'h0, d1} : {1'h0, d0}, rows[i].db);
			check("store", {7'h0, nv_cnt > n}, 8'h01);
		end
		// Every address pin setting answers its own address
		for (int a = 0; a < 8; a++) begin
			@(negedge core_clk) apins = a[2:0];
			addr_byte = {ADDR_HI, a[2:0], RW_WRITE};
			xfer({5'h0, a[2:0]}, 8'h00, 1'b0);
			check("addr_ack", {7'h0, ack}, 8'h01);
			check("wiper0", {2'h0, w0}, {5'h0, a[2:0]});
		end
		@(negedge core_clk) apins = 3'h2;
		xfer(8'h05, 8'h00, 1'b0);
		check("bad_addr", {7'h0, ack}, 8'h00);
		check("wiper0", {2'h0, w0}, 8'h07);
		@(negedge core_clk) apins = 3'h7;
		ce_block = 1'b1;
		xfer(8'h05, 8'h00, 1'b0);
		check("ce_ack", {7'h0, ack}, 8'h00);
		check("wiper0", {2'h0, w0}, 8'h07);
		ce_block = 1'b0;
		xfer(8'hc5, 8'h00, 1'b0);
		check("rsvd_ack", {7'h0, ack}, 8'h01);
		check("rsvd", {2'h0, vol, zce, opt, w0[2:0]}, 8'h0f);
		// Crossing on, nonvolatile: crossing applies pot0, expiry applies pot1
		xfer(8'h83, 8'h00, 1'b0);
		n0 = nv_cnt;
		fork
			xfer(8'h0a, 8'h4b, 1'b1);
			begin
				@(posedge busy[0]);
				repeat (5) @(negedge core_clk);
				check("zc_wait", {2'h0, w0}, 8'h07);
				eq0 = 1'b1;
				repeat (5) @(negedge core_clk);
				check("zc_apply", {2'h0, w0}, 8'h0a);
				eq1 = 1'b0;
				@(posedge busy[1]);
				for (n = 0; busy[1] && n < 200; n++) @(negedge core_clk);
				check("expiry", {7'h0, n >= WIN - 2 && n <= WIN + 2}, 8'h01);
				check("exp_apply", {2'h0, w1}, 8'h0b);
			end
		join
		repeat (5) @(negedge core_clk);
		check("bad_store", bad_nv[7:0], 8'h00);
		check("zc_store", {7'h0, nv_cnt > n0}, 8'h01);
		do_reset();
		// Volatile after reset: a wiper command moves the wiper but owes no store
		n0 = nv_cnt;
		xfer(8'h15, 8'h00, 1'b0);
		repeat (5) @(negedge core_clk);
		check("vol_wiper", {2'h0, w0}, 8'h15);
		check("vol_store", {7'h0, nv_cnt > n0}, 8'h00);
		results();
	end
endmodule : dual_log_pot_wiper_update_test
